/* File: src/port_status_pkg.sv */
package port_status_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PORTS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam int CTL_SELECT_LSB = 0;
  localparam int CTL_DIR1_BIT = 3;
  localparam int CTL_DIR2_BIT = 4;
  localparam int CTL_COUNT_ENABLE_BIT = 5;
  localparam int PORTS_OUT_LSB = 0;
  localparam int PORTS_SHARED_LSB = 4;
  localparam int IRQ_COUNT_END_BIT = 0;
  localparam int IRQ_UNLOCK_BIT = 1;
  localparam int IRQ_PIN1_BIT = 2;
  localparam int IRQ_PIN2_BIT = 3;
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam logic [5:0] PORTS_RESET = 6'h00;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [2:0] SEL_OPEN_A = 3'h0;
  localparam logic [2:0] SEL_UNLOCK = 3'h1;
  localparam logic [2:0] SEL_MEASURE_END = 3'h2;
  localparam logic [2:0] SEL_SHARED_1 = 3'h5;
  localparam logic [2:0] SEL_SHARED_2 = 3'h6;
endpackage

/* File: src/sync_bits.sv */
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_dout;

  // A change is accepted once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gBit
      always_comb begin
        next_dout[g] = (stage2[g] == stage3[g]) ? stage3[g] : dout[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout <= next_dout;
    end
  end
endmodule

/* File: src/port_and_status_pin_control.sv */
`timescale 1ns/1ps
// Operation
// - Port bit 0 open, 1 drives low.
// - Reset leaves all port outputs open.
// - Codes 000/011/100 open; 001 low on unlock.
// - 010 measure end; 101/110 mirror shared pins.
// - Reset selects status pin open.
// - Count enable rising releases status pin.
// - Count period end pulls status pin low.
// - Chip enable high returns status pin open, except code 001.
// - Mirroring an output-configured shared pin stays open.
module port_and_status_pin_control
  import port_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic pllUnlocked,
  input wire logic countDone,
  input wire logic chipEnable,
  output logic [3:0] outputPortOe,
  output logic [3:0] outputPortOut,
  input wire logic [1:0] sharedPinIn,
  output logic [1:0] sharedPinOe,
  output logic [1:0] sharedPinOut,
  output logic statusPinOe,
  output logic statusPinOut,
  output logic irq
);
  import port_status_pkg::*;

  typedef enum logic [1:0] {MEAS_IDLE, MEAS_COUNTING, MEAS_DONE} meas_t;

  logic [5:0] control;
  logic [5:0] portData;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;
  logic [5:0] next_control;
  logic [5:0] next_portData;
  logic [3:0] next_irqStatus;
  logic [3:0] next_irqMask;
  logic [31:0] next_wbDat;
  logic next_wbAck;
  meas_t measState;
  meas_t next_measState;
  logic prevCountEnable;
  logic prevUnlock;
  logic [1:0] prevShared;
  logic next_statusOe;
  logic [3:0] next_portOe;
  logic [1:0] next_sharedOe;
  logic next_irq;
  logic [2:0] syncIn;
  logic [2:0] syncOut;
  logic ceSync;
  logic unlockSync;
  logic [1:0] sharedSync;
  logic [2:0] selectCode;
  logic dir1;
  logic dir2;
  logic countEnable;
  logic busWrite;
  logic busRead;

  // Shared pins idle high, so they cross inverted and leave reset at their idle level.
  assign syncIn = {chipEnable, ~sharedPinIn};
  assign ceSync = syncOut[2];
  assign sharedSync = ~syncOut[1:0];
  assign unlockSync = pllUnlocked;
  assign selectCode = control[CTL_SELECT_LSB +: 3];
  assign dir1 = control[CTL_DIR1_BIT];
  assign dir2 = control[CTL_DIR2_BIT];
  assign countEnable = control[CTL_COUNT_ENABLE_BIT];
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign busRead = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  sync_bits #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(syncIn),
    .dout(syncOut)
  );

  function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [7:0] wr,
                                           input logic en);
    mergeByte = en ? wr : old;
  endfunction

  // Register file and sticky interrupt status; a set beats a write-one clear.
  always_comb begin
    next_control = control;
    next_portData = portData;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    next_wbAck = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_wbDat = '0;
    if (busWrite) begin
      case (wb_adr_i)
        ADDR_CONTROL: begin
          next_control = 6'(mergeByte({2'b00, control}, wb_dat_i[7:0], wb_sel_i[0]));
        end
        ADDR_PORTS: begin
          next_portData = 6'(mergeByte({2'b00, portData}, wb_dat_i[7:0], wb_sel_i[0]));
        end
        ADDR_IRQ_STATUS: begin
          if (wb_sel_i[0]) begin
            next_irqStatus = irqStatus & ~wb_dat_i[3:0];
          end
        end
        ADDR_IRQ_MASK: begin
          next_irqMask = 4'(mergeByte({4'h0, irqMask}, wb_dat_i[7:0], wb_sel_i[0]));
        end
        default: begin
        end
      endcase
    end
    if (busRead) begin
      case (wb_adr_i)
        ADDR_CONTROL: next_wbDat = {26'h0, control};
        ADDR_PORTS: next_wbDat = {26'h0, portData};
        ADDR_STATUS: next_wbDat = {24'h0, 2'b00, ceSync, unlockSync, sharedSync,
                                   measState == MEAS_DONE, statusPinOe};
        ADDR_IRQ_STATUS: next_wbDat = {28'h0, irqStatus};
        ADDR_IRQ_MASK: next_wbDat = {28'h0, irqMask};
        default: next_wbDat = '0;
      endcase
    end
    if (measState == MEAS_COUNTING && countDone) begin
      next_irqStatus[IRQ_COUNT_END_BIT] = 1'b1;
    end
    if (unlockSync && !prevUnlock) begin
      next_irqStatus[IRQ_UNLOCK_BIT] = 1'b1;
    end
    if (sharedSync[0] != prevShared[0]) begin
      next_irqStatus[IRQ_PIN1_BIT] = 1'b1;
    end
    if (sharedSync[1] != prevShared[1]) begin
      next_irqStatus[IRQ_PIN2_BIT] = 1'b1;
    end
    next_irq = |(next_irqStatus & next_irqMask);
  end

  // Measurement-end tracker.
  always_comb begin
    next_measState = measState;
    case (measState)
      MEAS_IDLE: begin
        if (countEnable && !prevCountEnable) begin
          next_measState = MEAS_COUNTING;
        end
      end
      MEAS_COUNTING: begin
        if (!countEnable) begin
          next_measState = MEAS_IDLE;
        end else if (countDone) begin
          next_measState = MEAS_DONE;
        end
      end
      MEAS_DONE: begin
        if (ceSync) begin
          next_measState = MEAS_IDLE;
        end else if (countEnable && !prevCountEnable) begin
          next_measState = MEAS_COUNTING;
        end
      end
      default: next_measState = MEAS_IDLE;
    endcase
  end

  // Pin drivers: enable high pulls the open-drain pin low.
  always_comb begin
    next_portOe = portData[PORTS_OUT_LSB +: 4];
    next_sharedOe[0] = dir1 && portData[PORTS_SHARED_LSB];
    next_sharedOe[1] = dir2 && portData[PORTS_SHARED_LSB + 1];
    case (selectCode)
      SEL_UNLOCK: next_statusOe = unlockSync;
      SEL_MEASURE_END: next_statusOe = (next_measState == MEAS_DONE) && !ceSync;
      SEL_SHARED_1: next_statusOe = !dir1 && !ceSync && !sharedSync[0];
      SEL_SHARED_2: next_statusOe = !dir2 && !ceSync && !sharedSync[1];
      default: next_statusOe = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      control <= CONTROL_RESET;
      portData <= PORTS_RESET;
      irqStatus <= 4'h0;
      irqMask <= IRQ_MASK_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      measState <= MEAS_IDLE;
      prevCountEnable <= 1'b0;
      prevUnlock <= 1'b0;
      prevShared <= 2'b11;
      outputPortOe <= 4'h0;
      sharedPinOe <= 2'b00;
      statusPinOe <= 1'b0;
      irq <= 1'b0;
    end else begin
      control <= next_control;
      portData <= next_portData;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      wb_ack_o <= next_wbAck;
      wb_dat_o <= next_wbDat;
      measState <= next_measState;
      prevCountEnable <= countEnable;
      prevUnlock <= unlockSync;
      prevShared <= sharedSync;
      outputPortOe <= next_portOe;
      sharedPinOe <= next_sharedOe;
      statusPinOe <= next_statusOe;
      irq <= next_irq;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      outputPortOut <= 4'h0;
      sharedPinOut <= 2'b00;
      statusPinOut <= 1'b0;
    end else begin
      outputPortOut <= 4'h0;
      sharedPinOut <= 2'b00;
      statusPinOut <= 1'b0;
    end
  end

  property p_reset_open;
    @(posedge clk_sys) $fell(rst) |-> !statusPinOe && outputPortOe == 4'h0;
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("pins not open after reset");

  property p_port_drive;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> outputPortOe == $past(portData[3:0]);
  endproperty
  a_port_drive: assert property (p_port_drive) else $error("output port drive wrong");

  property p_shared_input;
    @(posedge clk_sys) disable iff (rst) !dir1 |=> !sharedPinOe[0];
  endproperty
  a_shared_input: assert property (p_shared_input) else $error("input pin driven");

  property p_open_codes;
    @(posedge clk_sys) disable iff (rst)
      (selectCode == 3'h0 || selectCode == 3'h3 || selectCode == 3'h4) |=> !statusPinOe;
  endproperty
  a_open_codes: assert property (p_open_codes) else $error("status pin driven in open code");

  property p_unlock;
    @(posedge clk_sys) disable iff (rst)
      selectCode == SEL_UNLOCK |=> statusPinOe == $past(unlockSync);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock mirror wrong");

  property p_ce_release;
    @(posedge clk_sys) disable iff (rst) ceSync && selectCode != SEL_UNLOCK |=> !statusPinOe;
  endproperty
  a_ce_release: assert property (p_ce_release) else $error("status pin driven during CE");

  property p_count_end;
    @(posedge clk_sys) disable iff (rst)
      selectCode == SEL_MEASURE_END && measState == MEAS_COUNTING && countEnable && countDone
      && !ceSync |=> statusPinOe;
  endproperty
  a_count_end: assert property (p_count_end) else $error("count end not signalled");

  property p_count_start;
    @(posedge clk_sys) disable iff (rst)
      selectCode == SEL_MEASURE_END && measState != MEAS_COUNTING && countEnable
      && !prevCountEnable |=> !statusPinOe;
  endproperty
  a_count_start: assert property (p_count_start) else $error("count start not released");

  property p_mirror_output;
    @(posedge clk_sys) disable iff (rst) selectCode == SEL_SHARED_1 && dir1 |=> !statusPinOe;
  endproperty
  a_mirror_output: assert property (p_mirror_output) else $error("mirrored output pin");

  property p_mirror_output2;
    @(posedge clk_sys) disable iff (rst) selectCode == SEL_SHARED_2 && dir2 |=> !statusPinOe;
  endproperty
  a_mirror_output2: assert property (p_mirror_output2) else $error("mirrored output pin 2");

  property p_mirror_input;
    @(posedge clk_sys) disable iff (rst)
      selectCode == SEL_SHARED_1 && !dir1 && !ceSync |=> statusPinOe == !$past(sharedSync[0]);
  endproperty
  a_mirror_input: assert property (p_mirror_input) else $error("pin 1 level not mirrored");

  property p_shared_output;
    @(posedge clk_sys) disable iff (rst)
      dir2 |=> sharedPinOe[1] == $past(portData[PORTS_SHARED_LSB + 1]);
  endproperty
  a_shared_output: assert property (p_shared_output) else $error("output pin 2 drive wrong");
endmodule

/* File: dv/pin_partner.sv */
`timescale 1ns/1ps
module pin_partner (
  input wire logic clk_sys,
  input wire logic ceReq,
  input wire logic [1:0] extLow,
  input wire logic [1:0] sharedPinOe,
  output logic chipEnable,
  output logic [1:0] sharedPinIn
);
  // The host raises chip enable only while it frames a transfer.
  always @(posedge clk_sys) chipEnable <= ceReq;
  // Pull-ups hold each shared line high unless some party pulls it low.
  assign sharedPinIn = ~(sharedPinOe | extLow);
endmodule

/* File: dv/test_port_and_status_pin_control.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errCount++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module test_port_and_status_pin_control;
  import port_status_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  logic pllUnlocked = 1'b0;
  logic countDone = 1'b0;
  logic chipEnable;
  logic ceReq = 1'b0;
  logic [1:0] extLow = 2'h0;
  logic [3:0] outputPortOe, outputPortOut;
  logic [1:0] sharedPinIn, sharedPinOe, sharedPinOut;
  logic statusPinOe, statusPinOut, irq;
  logic [31:0] q;
  logic [5:0] ports;
  logic [1:0] dir, pin;
  logic [2:0] sel;
  int errCount = 0;
  int nChecks = 0;

  always #10 clk_sys = ~clk_sys;

  port_and_status_pin_control dut (.clk_sys, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pllUnlocked, .countDone,
    .chipEnable, .outputPortOe, .outputPortOut, .sharedPinIn, .sharedPinOe,
    .sharedPinOut, .statusPinOe, .statusPinOut, .irq);
  pin_partner host (.clk_sys, .ceReq, .extLow, .sharedPinOe, .chipEnable, .sharedPinIn);

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] r);
    int t;
    t = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (wb_ack_o !== 1'b1) errCount++;
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, 1'b1, d, r);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic pulse();
    @(posedge clk_sys);
    countDone <= 1'b1;
    @(posedge clk_sys);
    countDone <= 1'b0;
  endtask

  function automatic logic expSel(input logic [2:0] s, input logic [1:0] dr,
                                  input logic [1:0] p, input logic ul);
    case (s)
      SEL_UNLOCK: return ul;
      SEL_SHARED_1: return !dr[0] && !p[0];
      SEL_SHARED_2: return !dr[1] && !p[1];
      default: return 1'b0;
    endcase
  endfunction

  task automatic conclude();
    if (errCount == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200000;
    errCount++;
    conclude();
  end

  initial begin
    void'($urandom(46605));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK({outputPortOe, sharedPinOe, statusPinOe, irq}, 8'h00)
    wb(ADDR_CONTROL, 1'b0, 32'h0, q);
    `CHK(q[5:0], CONTROL_RESET)
    wb(ADDR_PORTS, 1'b0, 32'h0, q);
    `CHK(q[5:0], PORTS_RESET)
    wr(8'hFC, 32'hFFFFFFFF);
    wb(8'hFC, 1'b0, 32'h0, q);
    `CHK(q, 32'h0)
    for (int i = 0; i < 16; i++) begin
      ports = 6'($urandom);
      dir = i[3] ? 2'b11 : 2'b00;
      sel = i[2:0];
      pllUnlocked <= 1'($urandom);
      extLow <= 2'($urandom);
      wr(ADDR_PORTS, {26'h0, ports});
      wr(ADDR_CONTROL, {27'h0, dir, sel});
      settle();
      pin = ~((ports[5:4] & dir) | extLow);
      `CHK(outputPortOe, ports[3:0])
      `CHK(sharedPinOe, ports[5:4] & dir)
      `CHK(statusPinOe, expSel(sel, dir, pin, pllUnlocked))
    end
    `CHK({outputPortOut, sharedPinOut, statusPinOut}, 7'h00)
    pllUnlocked <= 1'b0;
    extLow <= 2'h0;
    wr(ADDR_IRQ_STATUS, 32'hF);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_CONTROL, {29'h0, SEL_MEASURE_END});
    wr(ADDR_CONTROL, {26'h0, 1'b1, 2'b00, SEL_MEASURE_END});
    settle();
    `CHK(statusPinOe, 1'b0)
    pulse();
    settle();
    `CHK({statusPinOe, irq}, 2'b11)
    wr(ADDR_IRQ_MASK, 32'h0);
    settle();
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_CONTROL, {29'h0, SEL_MEASURE_END});
    wr(ADDR_CONTROL, {26'h0, 1'b1, 2'b00, SEL_MEASURE_END});
    settle();
    `CHK({statusPinOe, irq}, 2'b01)
    pulse();
    settle();
    `CHK(statusPinOe, 1'b1)
    wb(ADDR_STATUS, 1'b0, 32'h0, q);
    `CHK(q, 32'h0000000F)
    ceReq <= 1'b1;
    settle();
    `CHK(statusPinOe, 1'b0)
    ceReq <= 1'b0;
    settle();
    `CHK(statusPinOe, 1'b0)
    extLow <= 2'b01;
    wr(ADDR_CONTROL, {29'h0, SEL_SHARED_1});
    settle();
    `CHK(statusPinOe, 1'b1)
    ceReq <= 1'b1;
    settle();
    `CHK(statusPinOe, 1'b0)
    ceReq <= 1'b0;
    settle();
    `CHK(statusPinOe, 1'b1)
    wr(ADDR_IRQ_STATUS, 32'hF);
    settle();
    `CHK(irq, 1'b0)
    conclude();
  end
endmodule
